// ===== verilog/aioc_params.svh
// Offsets, field positions, reset values and timing counts of the audio I/O control cells.
`ifndef AIOC_PARAMS_SVH
`define AIOC_PARAMS_SVH
`define AIOC_IDX_MAIN        12'h346
`define AIOC_IDX_IFC         12'h347
`define AIOC_IDX_OSC         12'h348
`define AIOC_IDX_STATUS      12'h360
`define AIOC_ADDR_MAIN       14'h0d18
`define AIOC_ADDR_IFC        14'h0d1c
`define AIOC_ADDR_OSC        14'h0d20
`define AIOC_ADDR_STATUS     14'h0d80
`define AIOC_RST_MAIN        20'h08025
`define AIOC_RST_IFC         20'h00005
`define AIOC_RST_OSC         20'h04800
`define AIOC_MAIN_WMASK      20'h0cb37
`define AIOC_IFC_WMASK       20'h0007f
`define AIOC_BIT_BLOCKIN     15
`define AIOC_BIT_SOC_INV     14
`define AIOC_BIT_OUT_DELAY   11
`define AIOC_BIT_INSEL_HI    9
`define AIOC_BIT_INSEL_LO    8
`define AIOC_BIT_WS_INV      5
`define AIOC_BIT_BITS16      4
`define AIOC_BIT_SIB_CLKINV  2
`define AIOC_BIT_PLL_LOCK    1
`define AIOC_BIT_VALIDATE    0
`define AIOC_BIT_SPDIF_SEL   6
`define AIOC_BIT_SPDIF_INV   5
`define AIOC_BIT_SDO_INV     3
`define AIOC_BIT_CLK_HIZ     2
`define AIOC_BIT_SDI_DIS     0
`define AIOC_TAKE_NS         64
`define AIOC_CLK_NS          8
`endif

// ===== verilog/aioc_pkg.sv
// Types shared by the audio I/O control cell files.
package aioc_pkg;
   typedef enum logic [1:0] {
      AIOC_IN_SERIAL_B = 2'h0,
      AIOC_IN_PARALLEL = 2'h1,
      AIOC_IN_RSVD2    = 2'h2,
      AIOC_IN_RSVD3    = 2'h3
   } aioc_insel_t;

   // Settings in force, after a validate.
   typedef struct packed {
      logic        block_input;
      logic        soc_invert;
      logic        out_delay;
      aioc_insel_t input_sel;
      logic        ws_invert;
      logic        bits16;
      logic        sib_clk_falling;
      logic        pll_locked_mode;
      logic        spdif_in2;
      logic        spdif_out_invalid;
      logic        sdo_invalid;
      logic        clk_high_z;
      logic        sdi_disable;
      logic [19:0] osc_khz;
   } aioc_cfg_t;
endpackage

// ===== verilog/aioc_takeover.sv
// Take-over sequencer that applies validated control changes after a fixed delay.
`timescale 1ns/10ps
`include "aioc_params.svh"
module aioc_takeover #(
   parameter int TAKE_CYCLES = ((`AIOC_TAKE_NS + `AIOC_CLK_NS - 1) / `AIOC_CLK_NS)
) (
   // Clock and reset.
   input  wire logic i_clk,
   input  wire logic i_rst_n,
   // Request and completion.
   input  wire logic i_start,
   output logic      o_busy,
   output logic      o_done
);
   typedef enum logic [1:0] {
      AIOC_TK_IDLE = 2'b00,
      AIOC_TK_WAIT = 2'b01,
      AIOC_TK_DONE = 2'b11
   } aioc_tk_state_t;

   aioc_tk_state_t state_q;
   aioc_tk_state_t state_d;
   logic [7:0]     cnt_q;
   logic [7:0]     cnt_d;
   wire logic      cnt_end = (cnt_q == 8'(TAKE_CYCLES - 1));

   // Next state: wait the take-over time, then signal completion for one cycle.
   always_comb begin
      state_d = state_q;
      cnt_d   = cnt_q;
      unique case (state_q)
         AIOC_TK_IDLE: begin
            cnt_d = 8'h00;
            if (i_start) begin
               state_d = AIOC_TK_WAIT;
            end
         end
         AIOC_TK_WAIT: begin
            cnt_d = cnt_q + 8'h01;
            if (cnt_end) begin
               state_d = AIOC_TK_DONE;
            end
         end
         AIOC_TK_DONE: begin
            state_d = AIOC_TK_IDLE;
         end
         default: begin
            state_d = AIOC_TK_IDLE;
         end
      endcase
   end

   // State register.
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         state_q <= AIOC_TK_IDLE;
         cnt_q   <= 8'h00;
      end else begin
         state_q <= state_d;
         cnt_q   <= cnt_d;
      end
   end

   assign o_busy = (state_q != AIOC_TK_IDLE);
   assign o_done = (state_q == AIOC_TK_DONE);
endmodule

// ===== verilog/aioc_cells.sv
// Audio I/O control cells: APB register bank, validate take-over and I/O steering.
// Notes on behaviour
// - A set serial output clock invert bit inverts the driven serial output clock.
// - A set output delay bit delays serial output data by one bit clock behind the strobe.
// - Coded audio enters on serial input B by default, or as 8-bit parallel words when selected.
// - A set word strobe invert bit, its reset state, inverts the outgoing word strobe.
// - Serial input B samples on the falling clock edge when its invert bit is set, else rising.
// - Bit 1 clear runs the PLL off as clock master; set enables the PLL locked to the data.
// - Writing one to validate makes the pending cell changes take effect.
// - Interface bit 6 selects S/PDIF input 1 when zero and input 2 when one.
// - Interface bit 3 marks serial audio output data valid when zero, invalid when one.
// - Interface bit 2 makes output clocks low impedance when zero, high impedance when one.
// - The oscillator cell holds the crystal frequency in kHz, reset 18432.
// - The device clears validate by itself once the changes are taken over.
//
// Decided for this implementation: register access over APB.
`timescale 1ns/10ps
`include "aioc_params.svh"
module aioc_cells (
   // Clock and reset.
   input  wire logic        i_clk,
   input  wire logic        i_rst_n,
   // APB slave.
   input  wire logic        i_psel,
   input  wire logic        i_penable,
   input  wire logic        i_pwrite,
   input  wire logic [13:0] i_paddr,
   input  wire logic [31:0] i_pwdata,
   output logic      [31:0] o_prdata,
   output logic             o_pready,
   output logic             o_pslverr,
   // Serial input B pins.
   input  wire logic        i_serial_input_b_clock,
   input  wire logic        i_serial_input_b,
   // Parallel port pins.
   input  wire logic [7:0]  i_parallel_port_pins,
   input  wire logic        i_parallel_strobe,
   // Coded audio towards the decoder.
   output logic [7:0]       o_coded_data,
   output logic             o_coded_valid,
   // Serial audio output.
   input  wire logic        i_sdo_bit_clk,
   input  wire logic        i_sdo_word_strobe,
   input  wire logic        i_sdo_data,
   output logic             o_sdo_clk,
   output logic             o_sdo_word_strobe,
   output logic             o_sdo_data,
   output logic             o_sdo_data_invalid,
   output logic             o_clk_high_z,
   // Clocking and S/PDIF controls.
   output logic             o_pll_enable,
   output logic             o_spdif_in2,
   output logic             o_spdif_out_invalid,
   output logic             o_sdi_disable,
   output logic [19:0]      o_osc_khz,
   output logic             o_block_input,
   output logic             o_bits16
);
   // Registered values written by software, shadowed until validate.
   logic [19:0]       main_q;
   logic [19:0]       ifc_q;
   logic [19:0]       osc_q;
   aioc_pkg::aioc_cfg_t cfg_q;
   logic              takes_q;

   // Bus decode.
   wire logic        acc       = i_psel && i_penable;
   wire logic        hit_main  = (i_paddr == `AIOC_ADDR_MAIN);
   wire logic        hit_ifc   = (i_paddr == `AIOC_ADDR_IFC);
   wire logic        hit_osc   = (i_paddr == `AIOC_ADDR_OSC);
   wire logic        hit_stat  = (i_paddr == `AIOC_ADDR_STATUS);
   wire logic        hit_any   = hit_main || hit_ifc || hit_osc || hit_stat;
   wire logic        wr_main   = acc && i_pwrite && hit_main;
   wire logic        wr_ifc    = acc && i_pwrite && hit_ifc;
   wire logic        wr_osc    = acc && i_pwrite && hit_osc;
   wire logic [19:0] wdata     = i_pwdata[19:0];
   wire logic        validate  = main_q[`AIOC_BIT_VALIDATE];
   wire logic        tk_busy;
   wire logic        tk_done;
   wire logic        tk_start  = validate && !tk_busy;

   // Take-over sequencer: a raised validate starts it; completion clears validate.
   aioc_takeover u_take (
      .i_clk   (i_clk),
      .i_rst_n (i_rst_n),
      .i_start (tk_start),
      .o_busy  (tk_busy),
      .o_done  (tk_done)
   );

   // Main control cell; a host write of one to validate wins over the self-clear.
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         main_q <= `AIOC_RST_MAIN;
      end else if (wr_main) begin
         main_q <= wdata & `AIOC_MAIN_WMASK;
      end else if (tk_done) begin
         main_q[`AIOC_BIT_VALIDATE] <= 1'b0;
      end
   end

   // Interface and oscillator cells store pending values only.
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         ifc_q <= `AIOC_RST_IFC;
         osc_q <= `AIOC_RST_OSC;
      end else begin
         if (wr_ifc) begin
            ifc_q <= wdata & `AIOC_IFC_WMASK;
         end
         if (wr_osc) begin
            osc_q <= wdata;
         end
      end
   end

   // Settings in force are loaded from the cells when take-over completes.
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         cfg_q <= '{block_input: 1'b0, soc_invert: 1'b0, out_delay: 1'b0,
                    input_sel: aioc_pkg::AIOC_IN_SERIAL_B, ws_invert: 1'b1,
                    bits16: 1'b0, sib_clk_falling: 1'b1, pll_locked_mode: 1'b0,
                    spdif_in2: 1'b0, spdif_out_invalid: 1'b0, sdo_invalid: 1'b0,
                    clk_high_z: 1'b1, sdi_disable: 1'b1, osc_khz: `AIOC_RST_OSC};
      end else if (tk_done) begin
         cfg_q.block_input       <= main_q[`AIOC_BIT_BLOCKIN];
         cfg_q.soc_invert        <= main_q[`AIOC_BIT_SOC_INV];
         cfg_q.out_delay         <= main_q[`AIOC_BIT_OUT_DELAY];
         cfg_q.input_sel         <= aioc_pkg::aioc_insel_t'(
                                    main_q[`AIOC_BIT_INSEL_HI:`AIOC_BIT_INSEL_LO]);
         cfg_q.ws_invert         <= main_q[`AIOC_BIT_WS_INV];
         cfg_q.bits16            <= main_q[`AIOC_BIT_BITS16];
         cfg_q.sib_clk_falling   <= main_q[`AIOC_BIT_SIB_CLKINV];
         cfg_q.pll_locked_mode   <= main_q[`AIOC_BIT_PLL_LOCK];
         cfg_q.spdif_in2         <= ifc_q[`AIOC_BIT_SPDIF_SEL];
         cfg_q.spdif_out_invalid <= ifc_q[`AIOC_BIT_SPDIF_INV];
         cfg_q.sdo_invalid       <= ifc_q[`AIOC_BIT_SDO_INV];
         cfg_q.clk_high_z        <= ifc_q[`AIOC_BIT_CLK_HIZ];
         cfg_q.sdi_disable       <= ifc_q[`AIOC_BIT_SDI_DIS];
         cfg_q.osc_khz           <= osc_q;
      end
   end

   // Take-over busy flag for the status word.
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         takes_q <= 1'b0;
      end else begin
         takes_q <= tk_busy;
      end
   end

   // Read mux and bus answer; unmapped addresses read zero with an error.
   wire logic [19:0] rd_word = hit_main ? main_q :
                               hit_ifc  ? ifc_q  :
                               hit_osc  ? osc_q  :
                               hit_stat ? {18'h00000, cfg_q.pll_locked_mode, takes_q} :
                                          20'h00000;
   assign o_pready  = 1'b1;
   assign o_pslverr = acc && !hit_any;
   assign o_prdata  = {12'h000, rd_word};

   // Two-flop synchronisers for the pins.
   logic [1:0] serial_input_b_clock_s_q;
   logic [1:0] sibd_s_q;
   logic [1:0] pstb_s_q;
   logic [7:0] ppin_s1_q;
   logic [7:0] ppin_s2_q;
   logic [1:0] bclk_s_q;
   logic [1:0] ws_s_q;
   logic [1:0] sdo_s_q;
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         serial_input_b_clock_s_q  <= 2'h0;
         sibd_s_q  <= 2'h0;
         pstb_s_q  <= 2'h0;
         ppin_s1_q <= 8'h00;
         ppin_s2_q <= 8'h00;
         bclk_s_q  <= 2'h0;
         ws_s_q    <= 2'h0;
         sdo_s_q   <= 2'h0;
      end else begin
         serial_input_b_clock_s_q  <= {serial_input_b_clock_s_q[0], i_serial_input_b_clock};
         sibd_s_q  <= {sibd_s_q[0], i_serial_input_b};
         pstb_s_q  <= {pstb_s_q[0], i_parallel_strobe};
         ppin_s1_q <= i_parallel_port_pins;
         ppin_s2_q <= ppin_s1_q;
         bclk_s_q  <= {bclk_s_q[0], i_sdo_bit_clk};
         ws_s_q    <= {ws_s_q[0], i_sdo_word_strobe};
         sdo_s_q   <= {sdo_s_q[0], i_sdo_data};
      end
   end

   // Edge history of the synchronised pins.
   logic serial_input_b_clock_d1_q;
   logic pstb_d1_q;
   logic bclk_d1_q;
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         serial_input_b_clock_d1_q <= 1'b0;
         pstb_d1_q <= 1'b0;
         bclk_d1_q <= 1'b0;
      end else begin
         serial_input_b_clock_d1_q <= serial_input_b_clock_s_q[1];
         pstb_d1_q <= pstb_s_q[1];
         bclk_d1_q <= bclk_s_q[1];
      end
   end

   // Serial input B sample edge follows the clock invert setting.
   wire logic sib_rise   = serial_input_b_clock_s_q[1] && !serial_input_b_clock_d1_q;
   wire logic sib_fall   = !serial_input_b_clock_s_q[1] && serial_input_b_clock_d1_q;
   wire logic sib_sample = cfg_q.sib_clk_falling ? sib_fall : sib_rise;
   wire logic par_mode   = (cfg_q.input_sel == aioc_pkg::AIOC_IN_PARALLEL);
   wire logic par_take   = pstb_s_q[1] && !pstb_d1_q;
   wire logic ser_mode   = (cfg_q.input_sel == aioc_pkg::AIOC_IN_SERIAL_B);

   // Serial input B bits are assembled MSB first into bytes.
   logic [6:0] sib_sh_q;
   logic [2:0] sib_cnt_q;
   always_ff @(posedge i_clk) begin
      if (!i_rst_n || !ser_mode) begin
         sib_sh_q  <= 7'h00;
         sib_cnt_q <= 3'h0;
      end else if (sib_sample) begin
         sib_sh_q  <= {sib_sh_q[5:0], sibd_s_q[1]};
         sib_cnt_q <= sib_cnt_q + 3'h1;
      end
   end
   wire logic sib_byte = ser_mode && sib_sample && (sib_cnt_q == 3'h7);

   // Coded audio output from the selected source.
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         o_coded_data  <= 8'h00;
         o_coded_valid <= 1'b0;
      end else begin
         o_coded_valid <= sib_byte || (par_mode && par_take);
         if (par_mode && par_take) begin
            o_coded_data <= ppin_s2_q;
         end else if (sib_byte) begin
            o_coded_data <= {sib_sh_q, sibd_s_q[1]};
         end
      end
   end

   // Serial output: optional one bit clock delay of data, polarity of clock and strobe.
   logic sdo_dly_q;
   wire logic bclk_fall = !bclk_s_q[1] && bclk_d1_q;
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         sdo_dly_q <= 1'b0;
      end else if (bclk_fall) begin
         sdo_dly_q <= sdo_s_q[1];
      end
   end

   // Serial output pins are registered.
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         o_sdo_clk         <= 1'b0;
         o_sdo_word_strobe <= 1'b1;
         o_sdo_data        <= 1'b0;
      end else begin
         o_sdo_clk         <= bclk_s_q[1] ^ cfg_q.soc_invert;
         o_sdo_word_strobe <= ws_s_q[1] ^ cfg_q.ws_invert;
         o_sdo_data        <= cfg_q.out_delay ? sdo_dly_q : sdo_s_q[1];
      end
   end

   // Static controls driven from the settings in force.
   assign o_sdo_data_invalid  = cfg_q.sdo_invalid;
   assign o_clk_high_z        = cfg_q.clk_high_z;
   assign o_pll_enable        = cfg_q.pll_locked_mode;
   assign o_spdif_in2         = cfg_q.spdif_in2;
   assign o_spdif_out_invalid = cfg_q.spdif_out_invalid;
   assign o_sdi_disable       = cfg_q.sdi_disable;
   assign o_osc_khz           = cfg_q.osc_khz;
   assign o_block_input       = cfg_q.block_input;
   assign o_bits16            = cfg_q.bits16;
endmodule

// ===== dv/aioc_cells_props.sv
// Checker for the audio I/O control cells, bound to the cell bank.
`timescale 1ns/10ps
`include "aioc_params.svh"
module aioc_cells_props (
   // Clock, reset and APB.
   input wire logic        i_clk,
   input wire logic        i_rst_n,
   input wire logic        i_psel,
   input wire logic        i_penable,
   input wire logic        i_pwrite,
   input wire logic [13:0] i_paddr,
   input wire logic [31:0] i_pwdata,
   input wire logic [31:0] o_prdata,
   input wire logic        o_pready,
   input wire logic        o_pslverr,
   // Serial output and applied settings.
   input wire logic        i_sdo_bit_clk,
   input wire logic        i_sdo_word_strobe,
   input wire logic        o_sdo_clk,
   input wire logic        o_sdo_word_strobe,
   input wire logic        o_pll_enable,
   input wire logic        o_clk_high_z,
   input wire logic        o_spdif_in2,
   input wire logic        o_sdo_data_invalid,
   input wire logic [19:0] o_osc_khz
);
   logic [4:0]  cnt_q;
   logic [19:0] osc_q;
   // Access decodes; 31 in the counter means no validate since reset.
   wire acc = i_psel && i_penable;
   wire val = acc && i_pwrite && i_paddr == `AIOC_ADDR_MAIN && i_pwdata[0];
   wire rdm = acc && !i_pwrite && i_paddr == `AIOC_ADDR_MAIN;
   wire map = i_paddr inside {`AIOC_ADDR_MAIN, `AIOC_ADDR_IFC, `AIOC_ADDR_OSC, `AIOC_ADDR_STATUS};
   // Cycles since the last validate, and the oscillator value last written.
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         cnt_q <= 5'h1f;
         osc_q <= `AIOC_RST_OSC;
      end else begin
         if (val) begin
            cnt_q <= 5'h00;
         end else if (cnt_q < 5'h1e) begin
            cnt_q <= cnt_q + 5'h01;
         end
         if (acc && i_pwrite && i_paddr == `AIOC_ADDR_OSC) begin
            osc_q <= i_pwdata[19:0];
         end
      end
   end
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_rst_n);
   pready_high_a: assert property (acc |-> o_pready) else $error("pready low");
   unmapped_err_a: assert property (acc && !map |-> o_pslverr && o_prdata == 32'h0)
      else $error("unmapped access not refused");
   reset_levels_a: assert property (!$past(i_rst_n) |-> o_clk_high_z && !o_pll_enable
      && !o_spdif_in2 && !o_sdo_data_invalid) else $error("bad level after reset");
   osc_reset_a: assert property (!$past(i_rst_n) |-> o_osc_khz == `AIOC_RST_OSC)
      else $error("oscillator reset value wrong");
   osc_apply_a: assert property (val |-> ##[1:14] o_osc_khz == osc_q)
      else $error("oscillator value not applied");
   pll_apply_a: assert property (val && i_pwdata[1] |-> ##[1:14] o_pll_enable)
      else $error("pll not enabled");
   no_early_a: assert property ($changed(o_osc_khz) || $changed(o_pll_enable)
      || $changed(o_clk_high_z) |-> cnt_q <= 5'd14) else $error("change without validate");
   self_clear_a: assert property (rdm && cnt_q inside {[15:30]} |-> !o_prdata[0])
      else $error("validate bit not cleared");
   soc_plain_a: assert property (cnt_q == 5'h1f && $past(i_rst_n, 3)
      |-> o_sdo_clk == $past(i_sdo_bit_clk, 3)) else $error("serial clock inverted");
   ws_invert_a: assert property (cnt_q == 5'h1f && $past(i_rst_n, 3)
      |-> o_sdo_word_strobe == !$past(i_sdo_word_strobe, 3)) else $error("strobe not inverted");
endmodule
bind aioc_cells aioc_cells_props u_props (.i_clk, .i_rst_n, .i_psel, .i_penable, .i_pwrite,
   .i_paddr, .i_pwdata, .o_prdata, .o_pready, .o_pslverr, .i_sdo_bit_clk, .i_sdo_word_strobe,
   .o_sdo_clk, .o_sdo_word_strobe, .o_pll_enable, .o_clk_high_z, .o_spdif_in2,
   .o_sdo_data_invalid, .o_osc_khz);

// ===== dv/aioc_host.sv
// Host model: an APB master that writes and reads the control cells.
`timescale 1ns/10ps
module aioc_host (
   // Clock and answer.
   input  wire logic        i_clk,
   input  wire logic        i_pready,
   // APB request.
   output logic             o_psel,
   output logic             o_penable,
   output logic             o_pwrite,
   output logic [13:0]      o_paddr,
   output logic [31:0]      o_pwdata
);
   int n_to;
   // Idle bus from time zero.
   initial begin
      n_to = 0;
      o_psel = 1'b0;
      o_penable = 1'b0;
      o_pwrite = 1'b0;
      o_paddr = 14'h0000;
      o_pwdata = 32'h0;
   end
   // Setup, then access held until pready is seen high at an edge.
   // The application running cell lies outside this block, so it reads as ready.
   task automatic xfer(input logic w, input logic [13:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge i_clk);
      o_psel <= 1'b1;
      o_pwrite <= w;
      o_paddr <= a;
      o_pwdata <= d;
      @(posedge i_clk);
      o_penable <= 1'b1;
      do begin
         @(posedge i_clk);
         n++;
      end while (i_pready !== 1'b1 && n < 50);
      if (n >= 50) n_to++;
      o_psel <= 1'b0;
      o_penable <= 1'b0;
   endtask
endmodule

// ===== dv/aioc_cells_tb.sv
// Self-checking testbench for the audio I/O control cells.
`timescale 1ns/10ps
`include "aioc_params.svh"
module aioc_cells_tb;
   logic        i_clk, i_rst_n, i_psel, i_penable, i_pwrite, o_pready, o_pslverr;
   logic [13:0] i_paddr;
   logic [31:0] i_pwdata, o_prdata, ifc, exp_q[$], cod_q[$];
   logic [7:0]  i_parallel_port_pins, o_coded_data, cyc;
   logic        i_serial_input_b_clock, i_serial_input_b, i_parallel_strobe, o_coded_valid;
   logic        i_sdo_bit_clk, i_sdo_word_strobe, i_sdo_data, o_sdo_clk, o_sdo_word_strobe;
   logic        o_sdo_data, o_sdo_data_invalid, o_clk_high_z, o_pll_enable, o_spdif_in2;
   logic        o_spdif_out_invalid, o_sdi_disable, o_block_input, o_bits16, sdo_run;
   logic        bclk_q, sdo_fall_q;
   logic [19:0] o_osc_khz, osc;
   int          n_fail, n_tests, seed;
   aioc_host i_host (.i_clk, .i_pready(o_pready), .o_psel(i_psel), .o_penable(i_penable),
      .o_pwrite(i_pwrite), .o_paddr(i_paddr), .o_pwdata(i_pwdata));
   aioc_cells i_dut (.i_clk, .i_rst_n, .i_psel, .i_penable, .i_pwrite, .i_paddr, .i_pwdata,
      .o_prdata, .o_pready, .o_pslverr, .i_serial_input_b_clock, .i_serial_input_b,
      .i_parallel_port_pins, .i_parallel_strobe, .o_coded_data, .o_coded_valid,
      .i_sdo_bit_clk, .i_sdo_word_strobe, .i_sdo_data, .o_sdo_clk, .o_sdo_word_strobe,
      .o_sdo_data, .o_sdo_data_invalid, .o_clk_high_z, .o_pll_enable, .o_spdif_in2,
      .o_spdif_out_invalid, .o_sdi_disable, .o_osc_khz, .o_block_input, .o_bits16);
   // Clock at 125 MHz.
   initial begin
      i_clk = 1'b0;
      forever #4 i_clk = ~i_clk;
   end
   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         n_fail++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic print_verdict;
      n_fail += i_host.n_to;
      $display("compares=%0d mismatches=%0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   task automatic rd(input logic [13:0] a, input logic [31:0] e);
      exp_q.push_back(e);
      i_host.xfer(1'b0, a, 32'h0);
   endtask
   // Validate, then wait out the take-over time.
   task automatic validate(input logic [31:0] d);
      i_host.xfer(1'b1, `AIOC_ADDR_MAIN, d);
      repeat (16) @(posedge i_clk);
   endtask
   // One byte on serial input B, most significant bit first; the data line flips between the
   // clock edges, so only the edge chosen by fall sees the true bit.
   task automatic ser(input logic [7:0] b, input logic fall);
      cod_q.push_back({24'h0, b});
      for (int k = 7; k >= 0; k--) begin
         i_serial_input_b <= b[k] ^ fall;
         repeat (4) @(posedge i_clk);
         i_serial_input_b_clock <= 1'b1;
         repeat (4) @(posedge i_clk);
         i_serial_input_b <= b[k] ^ !fall;
         repeat (4) @(posedge i_clk);
         i_serial_input_b_clock <= 1'b0;
         repeat (4) @(posedge i_clk);
      end
   endtask
   task automatic par(input logic [7:0] b);
      cod_q.push_back({24'h0, b});
      i_parallel_port_pins <= b;
      repeat (2) @(posedge i_clk);
      i_parallel_strobe <= 1'b1;
      repeat (4) @(posedge i_clk);
      i_parallel_strobe <= 1'b0;
      repeat (8) @(posedge i_clk);
   endtask
   // Free-running serial output traffic from the core side; the data at each bit clock fall
   // is kept as the expected delayed output.
   always @(posedge i_clk) begin
      cyc <= cyc + 8'h01;
      bclk_q <= i_sdo_bit_clk;
      if (bclk_q && !i_sdo_bit_clk) sdo_fall_q <= i_sdo_data;
      if (sdo_run && cyc[2:0] == 3'h7) begin
         i_sdo_bit_clk <= ~i_sdo_bit_clk;
         i_sdo_data <= 1'($urandom);
      end
      if (sdo_run && cyc[5:0] == 6'h3f) i_sdo_word_strobe <= ~i_sdo_word_strobe;
   end
   // Takes the oldest note off a queue whenever a read or a coded byte appears.
   // A result with no note waiting counts as a mismatch.
   always @(posedge i_clk) begin
      if (i_psel && i_penable && !i_pwrite && o_pready) begin
         if (exp_q.size() == 0) n_fail++;
         else cmp(o_prdata, exp_q.pop_front());
      end
      if (o_coded_valid === 1'b1) begin
         if (cod_q.size() == 0) n_fail++;
         else cmp({24'h0, o_coded_data}, cod_q.pop_front());
      end
   end
   // Watchdog against a hang.
   initial begin
      repeat (20000) @(posedge i_clk);
      n_fail++;
      print_verdict();
   end
   initial begin
      seed = $urandom(32'h9d8f70f0);
      {i_rst_n, i_serial_input_b_clock, i_serial_input_b, i_parallel_strobe} = 4'h0;
      {i_sdo_bit_clk, i_sdo_word_strobe, i_sdo_data, i_parallel_port_pins} = 11'h0;
      {bclk_q, sdo_fall_q, cyc} = 10'h000;
      sdo_run = 1'b1;
      repeat (20) @(posedge i_clk);
      i_rst_n <= 1'b1;
      rd(`AIOC_ADDR_MAIN, 32'h8025);
      rd(`AIOC_ADDR_IFC, 32'h5);
      rd(`AIOC_ADDR_OSC, 32'h4800);
      rd(`AIOC_ADDR_STATUS, 32'h0);
      rd(14'h0d24, 32'h0);
      osc = 20'($urandom);
      ifc = $urandom;
      i_host.xfer(1'b1, `AIOC_ADDR_OSC, {12'h0, osc});
      i_host.xfer(1'b1, `AIOC_ADDR_IFC, ifc);
      rd(`AIOC_ADDR_IFC, ifc & 32'h7f);
      rd(`AIOC_ADDR_OSC, {12'h0, osc});
      i_host.xfer(1'b1, `AIOC_ADDR_MAIN, 32'h0000cb36);
      rd(`AIOC_ADDR_MAIN, 32'hcb36);
      cmp({12'h0, o_osc_khz}, {12'h0, `AIOC_RST_OSC});
      validate(32'h4007);
      rd(`AIOC_ADDR_MAIN, 32'h4006);
      cmp({12'h0, o_osc_khz}, {12'h0, osc});
      cmp({31'h0, o_pll_enable}, 32'h1);
      cmp(32'({o_clk_high_z, o_spdif_in2, o_sdo_data_invalid, o_spdif_out_invalid}),
          32'({ifc[2], ifc[6], ifc[3], ifc[5]}));
      cmp(32'({o_sdi_disable, o_block_input, o_bits16}), 32'({ifc[0], 2'b00}));
      sdo_run <= 1'b0;
      repeat (6) @(posedge i_clk);
      cmp({31'h0, o_sdo_clk}, {31'h0, !i_sdo_bit_clk});
      cmp({31'h0, o_sdo_word_strobe}, {31'h0, i_sdo_word_strobe});
      cmp({31'h0, o_sdo_data}, {31'h0, i_sdo_data});
      sdo_run <= 1'b1;
      ser(8'($urandom), 1'b1);
      ser(8'($urandom), 1'b1);
      validate(32'h4003);
      ser(8'($urandom), 1'b0);
      validate(32'h8915);
      cmp({31'h0, o_pll_enable}, 32'h0);
      cmp(32'({o_block_input, o_bits16}), 32'h3);
      par(8'($urandom));
      par(8'($urandom));
      sdo_run <= 1'b0;
      repeat (6) @(posedge i_clk);
      cmp({31'h0, o_sdo_data}, {31'h0, sdo_fall_q});
      cmp({31'h0, o_sdo_clk}, {31'h0, i_sdo_bit_clk});
      repeat (20) @(posedge i_clk);
      cmp(exp_q.size() + cod_q.size(), 32'h0);
      print_verdict();
   end
endmodule
